// ===== cbi_pkg.sv
// Purpose: shared constants for the bus-integration and edge-filter block
// Assumes: one 20 MHz clock, time quantum derived by an enable divider
// Notes:   all counts are derived from times where a time is given
package cbi_pkg;
   // clock and time quantum
   localparam int CLK_NS      = 50;          // ref_clk period
   localparam int TQ_NS       = 250;         // one time quantum
   localparam int TQ_CYCLES   = (TQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int TQ_CNT_W    = 3;
   // nominal bit layout, in time quanta
   localparam int NBT_TQ      = 10;          // quanta per bit
   localparam int SAMPLE_TQ   = 7;           // quantum index of the sample point
   localparam int TQ_IDX_W    = 4;
   // idle detection
   localparam int IDLE_BITS   = 11;          // recessive bits to integrate
   localparam int IDLE_CNT_W  = 4;
   // receive glitch filter
   localparam int GLITCH_LEN  = 3;           // samples that must agree
   // levels and reset values
   localparam logic RECESSIVE = 1'b1;
   localparam logic DOMINANT  = 1'b0;
   localparam logic [TQ_IDX_W-1:0]   TQ_IDX_RST  = 4'h0;
   localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_RST = 4'h0;
   localparam logic [TQ_CNT_W-1:0]   TQ_DIV_RST  = 3'h0;

   typedef enum logic [1:0] {
      CBI_HELD,
      CBI_INTEGRATE,
      CBI_ACTIVE
   } cbi_state_e;
endpackage : cbi_pkg

// ===== cbi_tq_div.sv
// Purpose: time-quantum enable generator
// Assumes: TQ_CYCLES of at least one
// Notes:   tick is a one-cycle pulse, the only slower rate in the block
`timescale 1ns/100ps
module cbi_tq_div (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   output logic      tqTick
);
   logic [cbi_pkg::TQ_CNT_W-1:0] divCnt;
   logic [cbi_pkg::TQ_CNT_W-1:0] next_divCnt;
   logic                         next_tqTick;

   // wrap counter, tick on the last count
   always_comb begin
      next_tqTick = (divCnt == cbi_pkg::TQ_CNT_W'(cbi_pkg::TQ_CYCLES - 1));
      next_divCnt = next_tqTick ? cbi_pkg::TQ_DIV_RST : divCnt + 1'b1;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         divCnt <= cbi_pkg::TQ_DIV_RST;
         tqTick <= 1'b0;
      end else begin
         divCnt <= next_divCnt;
         tqTick <= next_tqTick;
      end
   end
endmodule : cbi_tq_div

// ===== cbi_edge_filter.sv
// Purpose: edge filter that needs two dominant quanta in a row
// Assumes: rxIn already glitch filtered, tqTick one pulse per quantum
// Notes:   a dominant level reaches the output one quantum late, a recessive one at the next tick; caller picks when to use it
`timescale 1ns/100ps
module cbi_edge_filter (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic tqTick,
   input  wire logic rxIn,
   output logic      rxFiltered
);
   logic lastTq;
   logic next_lastTq;
   logic next_rxFiltered;

   // dominant only when this and the previous quantum are dominant
   always_comb begin
      next_lastTq     = tqTick ? rxIn : lastTq;
      next_rxFiltered = tqTick ? (rxIn | lastTq) : rxFiltered;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lastTq     <= cbi_pkg::RECESSIVE;
         rxFiltered <= cbi_pkg::RECESSIVE;
      end else begin
         lastTq     <= next_lastTq;
         rxFiltered <= next_rxFiltered;
      end
   end
endmodule : cbi_edge_filter

// ===== cbi_integration.sv
// Purpose: bus integration, idle detection and frame-start CRC resets
// Assumes: inputs synchronous to ref_clk; frame decoding done elsewhere
// Notes:   filter use is decided here, the filter itself runs always
//
// Summary of operation
// - Edge filtering is used only while integrating with the filter enable set, never after.
// - Integration ends at the sample point of the eleventh recessive bit in a row.
// - With the filter on, only two dominant quanta in a row restart the idle count.
// - With the filter on, bit timing works on the delayed filtered receive level.
// - At each frame start the FD CRC and classical CRC resets are issued together, in the same cycle.
// - An FD frame whose CRC does not match is faulty and an error frame is requested.
// - Clearing the initialisation bit starts integration.
// - A protocol exception starts integration only when exception handling is enabled.
// - Integration begun mid-frame counts the recessive bits from acknowledge to next start.
// - The receive glitch filter is always active, whatever the edge filter setting.
`timescale 1ns/100ps
module cbi_integration (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic rxPin,
   input  wire logic initCtrl,
   input  wire logic edgeFilterIntegrationEnable,
   input  wire logic protocolExceptionHandlingDisable,
   input  wire logic protocolException,
   input  wire logic frameEnd,
   input  wire logic fdFrame,
   input  wire logic crcMismatch,
   output logic      integrating,
   output logic      busIntegrated,
   output logic      filterActive,
   output logic      sampleValid,
   output logic      sampleBit,
   output logic      fdCrcReset,
   output logic      classicCrcReset,
   output logic      errorFrameReq
);
   logic                           tqTick;
   logic                           rxFiltered;
   logic [cbi_pkg::GLITCH_LEN-1:0] rxShift;
   logic [cbi_pkg::GLITCH_LEN-1:0] next_rxShift;
   logic                           glitchRx;
   logic                           next_glitchRx;
   logic                           btRx;
   logic                           btRxPrev;
   logic                           next_btRxPrev;
   logic [cbi_pkg::TQ_IDX_W-1:0]   tqIdx;
   logic [cbi_pkg::TQ_IDX_W-1:0]   next_tqIdx;
   logic [cbi_pkg::IDLE_CNT_W-1:0] recCnt;
   logic [cbi_pkg::IDLE_CNT_W-1:0] next_recCnt;
   logic                           sampleEn;
   logic                           fallEdge;
   logic                           sofDet;
   logic                           inFrame;
   logic                           next_inFrame;
   cbi_pkg::cbi_state_e            state;
   cbi_pkg::cbi_state_e            next_state;
   logic                           next_sampleValid;
   logic                           next_sampleBit;
   logic                           next_fdCrcReset;
   logic                           next_classicCrcReset;
   logic                           next_errorFrameReq;

   cbi_tq_div u_div (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .tqTick  (tqTick)
   );

   cbi_edge_filter u_filt (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .tqTick     (tqTick),
      .rxIn       (glitchRx),
      .rxFiltered (rxFiltered)
   );

   // glitch filter: level moves only when all recent samples agree
   always_comb begin
      next_rxShift  = {rxShift[cbi_pkg::GLITCH_LEN-2:0], rxPin};
      next_glitchRx = glitchRx;
      if (&rxShift) begin
         next_glitchRx = cbi_pkg::RECESSIVE;
      end else if (~|rxShift) begin
         next_glitchRx = cbi_pkg::DOMINANT;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxShift  <= {cbi_pkg::GLITCH_LEN{cbi_pkg::RECESSIVE}};
         glitchRx <= cbi_pkg::RECESSIVE;
      end else begin
         rxShift  <= next_rxShift;
         glitchRx <= next_glitchRx;
      end
   end

   // filter use is tied to the state, so it drops by itself at the end
   assign filterActive = (state == cbi_pkg::CBI_INTEGRATE) && edgeFilterIntegrationEnable;
   assign btRx         = filterActive ? rxFiltered : glitchRx;
   assign integrating  = (state == cbi_pkg::CBI_INTEGRATE);
   assign busIntegrated = (state == cbi_pkg::CBI_ACTIVE);

   // bit timing: hard sync on a falling edge outside a frame
   assign fallEdge = tqTick && btRxPrev && !btRx;
   assign sampleEn = tqTick && (tqIdx == cbi_pkg::TQ_IDX_W'(cbi_pkg::SAMPLE_TQ));
   assign sofDet   = fallEdge && (state == cbi_pkg::CBI_ACTIVE) && !inFrame;

   always_comb begin
      next_btRxPrev = tqTick ? btRx : btRxPrev;
      next_tqIdx    = tqIdx;
      if (tqTick) begin
         if (fallEdge && !inFrame) begin
            next_tqIdx = cbi_pkg::TQ_IDX_W'(1);  // edge quantum is the sync segment
         end else if (tqIdx == cbi_pkg::TQ_IDX_W'(cbi_pkg::NBT_TQ - 1)) begin
            next_tqIdx = cbi_pkg::TQ_IDX_RST;
         end else begin
            next_tqIdx = tqIdx + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         btRxPrev <= cbi_pkg::RECESSIVE;
         tqIdx    <= cbi_pkg::TQ_IDX_RST;
      end else begin
         btRxPrev <= next_btRxPrev;
         tqIdx    <= next_tqIdx;
      end
   end

   // integration state and idle count
   // a mid-frame start simply counts on until the end-of-frame run is long enough
   always_comb begin
      next_state  = state;
      next_recCnt = recCnt;
      case (state)
         cbi_pkg::CBI_HELD: begin
            next_recCnt = cbi_pkg::IDLE_CNT_RST;
            if (!initCtrl) begin
               next_state = cbi_pkg::CBI_INTEGRATE;
            end
         end
         cbi_pkg::CBI_INTEGRATE: begin
            if (sampleEn) begin
               if (btRx == cbi_pkg::RECESSIVE) begin
                  if (recCnt == cbi_pkg::IDLE_CNT_W'(cbi_pkg::IDLE_BITS - 1)) begin
                     next_state  = cbi_pkg::CBI_ACTIVE;
                     next_recCnt = cbi_pkg::IDLE_CNT_RST;
                  end else begin
                     next_recCnt = recCnt + 1'b1;
                  end
               end else begin
                  // with the filter on, a lone dominant quantum never gets here
                  next_recCnt = cbi_pkg::IDLE_CNT_RST;
               end
            end
         end
         cbi_pkg::CBI_ACTIVE: begin
            if (protocolException && !protocolExceptionHandlingDisable) begin
               next_state  = cbi_pkg::CBI_INTEGRATE;
               next_recCnt = cbi_pkg::IDLE_CNT_RST;
            end
         end
         default: begin
            next_state  = cbi_pkg::CBI_HELD;
            next_recCnt = cbi_pkg::IDLE_CNT_RST;
         end
      endcase
      if (initCtrl) begin
         next_state = cbi_pkg::CBI_HELD;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state  <= cbi_pkg::CBI_HELD;
         recCnt <= cbi_pkg::IDLE_CNT_RST;
      end else begin
         state  <= next_state;
         recCnt <= next_recCnt;
      end
   end

   // frame tracking, CRC resets and error request
   // two separate reset strobes so the classical path owes nothing to FD timing
   always_comb begin
      next_inFrame         = inFrame;
      if (frameEnd || state != cbi_pkg::CBI_ACTIVE) begin
         next_inFrame = 1'b0;
      end
      // a start wins over the clear, but sofDet is masked while inFrame is still set, so none is seen in the closing cycle
      if (sofDet) begin
         next_inFrame = 1'b1;
      end
      next_fdCrcReset      = sofDet;
      next_classicCrcReset = sofDet;
      next_errorFrameReq   = frameEnd && fdFrame && crcMismatch
                             && (state == cbi_pkg::CBI_ACTIVE);
      next_sampleValid     = sampleEn;
      next_sampleBit       = sampleEn ? btRx : sampleBit;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         inFrame         <= 1'b0;
         fdCrcReset      <= 1'b0;
         classicCrcReset <= 1'b0;
         errorFrameReq   <= 1'b0;
         sampleValid     <= 1'b0;
         sampleBit       <= cbi_pkg::RECESSIVE;
      end else begin
         inFrame         <= next_inFrame;
         fdCrcReset      <= next_fdCrcReset;
         classicCrcReset <= next_classicCrcReset;
         errorFrameReq   <= next_errorFrameReq;
         sampleValid     <= next_sampleValid;
         sampleBit       <= next_sampleBit;
      end
   end

   // checks
   filt_only_integ_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (state != cbi_pkg::CBI_INTEGRATE) |-> !filterActive)
      else $error("edge filter active outside integration");

   filt_on_integ_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (state == cbi_pkg::CBI_INTEGRATE && edgeFilterIntegrationEnable) |-> filterActive)
      else $error("edge filter not used while integrating");

   end_at_eleven_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (state == cbi_pkg::CBI_INTEGRATE && sampleEn && btRx && !initCtrl
       && recCnt == 4'hA) |=> (state == cbi_pkg::CBI_ACTIVE))
      else $error("integration did not end at eleventh recessive bit");

   no_early_end_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (state == cbi_pkg::CBI_INTEGRATE && recCnt < 4'hA)
      |=> (state != cbi_pkg::CBI_ACTIVE))
      else $error("integration ended before eleven recessive bits");

   dom_restart_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (state == cbi_pkg::CBI_INTEGRATE && sampleEn && !btRx && !initCtrl)
      |=> (recCnt == 4'h0))
      else $error("dominant sample did not restart idle count");

   bt_source_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      filterActive |-> (btRx == rxFiltered))
      else $error("bit timing not on filtered level");

   crc_resets_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      sofDet |=> (fdCrcReset && classicCrcReset) ##1 (!fdCrcReset && !classicCrcReset))
      else $error("crc resets not issued at frame start");

   err_frame_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (state == cbi_pkg::CBI_ACTIVE && frameEnd && fdFrame && crcMismatch)
      |=> errorFrameReq)
      else $error("fd crc mismatch without error frame");

   init_enter_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (state == cbi_pkg::CBI_HELD && !initCtrl) |=> (state == cbi_pkg::CBI_INTEGRATE))
      else $error("init clear did not start integration");

   exc_gate_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (state == cbi_pkg::CBI_ACTIVE && protocolException && !initCtrl)
      |=> (state == (protocolExceptionHandlingDisable ? cbi_pkg::CBI_ACTIVE
                                                      : cbi_pkg::CBI_INTEGRATE)))
      else $error("protocol exception handled against its disable");

   glitch_hold_a: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      $changed(glitchRx) |-> ($past(rxShift) == 3'h0 || $past(rxShift) == 3'h7))
      else $error("receive level moved on a glitch");
endmodule : cbi_integration

// ===== cbi_bus_node.sv
// Purpose: behavioural model of the other nodes on the bus, seen through the transceiver
// Assumes: bus pulled recessive whenever no node drives dominant
// Notes:   bench calls pulse() for frames, spikes and glitches
`timescale 1ns/100ps
module cbi_bus_node #(
   parameter int RETX_GAP = 150
) (
   input  wire logic ref_clk,
   input  wire logic errorFrameReq,
   output logic      busLevel
);
   // idle bus is recessive, never left floating
   initial busLevel = cbi_pkg::RECESSIVE;

   // drive dominant for len clocks, changing just after an edge
   task automatic pulse(input int len);
      @(posedge ref_clk);
      #1 busLevel = cbi_pkg::DOMINANT;
      repeat (len) @(posedge ref_clk);
      #1 busLevel = cbi_pkg::RECESSIVE;
   endtask : pulse

   // sender answers an error frame by starting the frame again
   always @(posedge ref_clk) begin
      if (errorFrameReq === 1'b1) begin
         repeat (RETX_GAP) @(posedge ref_clk);
         pulse(cbi_pkg::NBT_TQ * cbi_pkg::TQ_CYCLES);
      end
   end
endmodule : cbi_bus_node

// ===== cbi_integration_bench.sv
// Purpose: self-checking bench for bus integration and frame-start strobes
// Assumes: timings as set by the package constants, bus model on rxPin
// Notes:   hard sync may move sample points, so bounds carry one bit of slack
`timescale 1ns/100ps
module cbi_integration_bench;
   localparam int BIT  = cbi_pkg::NBT_TQ * cbi_pkg::TQ_CYCLES;
   localparam int ILO  = (cbi_pkg::IDLE_BITS - 1) * BIT;
   localparam int IHI  = (cbi_pkg::IDLE_BITS + 1) * BIT + 20;
   logic ref_clk, arst_n, rxPin, initCtrl, filtEn, pxDis, protocolException;
   logic frameEnd, fdFrame, crcMismatch, integrating, busIntegrated, filterActive;
   logic sampleValid, sampleBit, fdCrcReset, classicCrcReset, errorFrameReq, mm;
   int   n_fail, checked, cyc, n, off;

   cbi_integration u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .rxPin(rxPin),
      .initCtrl(initCtrl), .edgeFilterIntegrationEnable(filtEn),
      .protocolExceptionHandlingDisable(pxDis), .protocolException(protocolException),
      .frameEnd(frameEnd), .fdFrame(fdFrame), .crcMismatch(crcMismatch),
      .integrating(integrating), .busIntegrated(busIntegrated),
      .filterActive(filterActive), .sampleValid(sampleValid), .sampleBit(sampleBit),
      .fdCrcReset(fdCrcReset), .classicCrcReset(classicCrcReset),
      .errorFrameReq(errorFrameReq));
   cbi_bus_node u_node (.ref_clk(ref_clk), .errorFrameReq(errorFrameReq), .busLevel(rxPin));

   // clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // hang guard, ceiling well above the expected few thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         results();
      end
   end

   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk

   function automatic logic sig(input int sel);
      case (sel)
         0: return busIntegrated;
         1: return fdCrcReset;
         default: return integrating;
      endcase
   endfunction : sig

   // bounded wait, cnt stays -1 when the signal never rose
   task automatic waitSig(input int sel, input int lim, output int cnt);
      cnt = -1;
      for (int i = 0; i < lim; i++) begin
         if (sig(sel) === 1'b1) begin
            cnt = i;
            break;
         end
         tick();
      end
   endtask : waitSig

   // hold, release, disturb the bus at spk for len clocks, time the join
   task automatic integ(input logic en, input int spk, input int len);
      int lo;
      int hi;
      lo = (len >= BIT) ? spk + len + ILO : ILO;
      hi = (len >= BIT) ? spk + len + IHI : IHI;
      initCtrl = 1'b1;
      tick();
      tick();
      chk(integrating === 1'b0 && busIntegrated === 1'b0, "init bit not holding");
      filtEn = en;
      initCtrl = 1'b0;
      tick();
      chk(integrating === 1'b1 && filterActive === en, "integration start");
      fork
         begin
            repeat (spk) tick();
            u_node.pulse(len);
         end
         waitSig(0, hi + 10, n);
      join
      chk(n >= lo && n <= hi, "idle count timing");
      chk(filterActive === 1'b0 && integrating === 1'b0, "filter still on");
   endtask : integ

   // frame start strobes, then the CRC verdict at frame end
   task automatic frame(input logic bad);
      fork
         u_node.pulse(BIT);
         waitSig(1, 20, n);
      join
      chk(n >= 0, "no FD CRC reset at frame start");
      chk(sampleBit === 1'b0, "start bit not sampled dominant");
      repeat (2 * BIT) tick();
      {frameEnd, fdFrame, crcMismatch} = {1'b1, 1'b1, bad};
      tick();
      frameEnd = 1'b0;
      chk(errorFrameReq === bad, "error frame request");
      if (bad) begin
         waitSig(1, 4 * BIT, n);
         chk(n >= 0, "retransmitted frame not seen");
         repeat (2 * BIT) tick();
         {frameEnd, crcMismatch} = 2'h2;
         tick();
         frameEnd = 1'b0;
      end
   endtask : frame

   task automatic results();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results

   // CRC reset watch; classic reset is probed inside the FD reset cycle
   always @(posedge ref_clk) begin
      if (fdCrcReset === 1'b1) begin
         chk(classicCrcReset === 1'b1, "CRC resets not together");
      end
   end

   initial begin
      // exceptions start out disabled so the first one must be ignored
      {arst_n, initCtrl, filtEn, pxDis} = 4'h7;
      {protocolException, frameEnd, fdFrame, crcMismatch} = 4'h0;
      n_fail = 0;
      checked = 0;
      cyc = 0;
      void'($urandom(32'h3451));
      repeat (5) @(posedge ref_clk);
      #1 arst_n = 1'b1;
      repeat (20) tick();
      chk(integrating === 1'b0 && busIntegrated === 1'b0 && filterActive === 1'b0
          && sampleBit === 1'b1, "reset state");
      // idle bus, no hard sync: exactly one sample strobe per bit time
      n = 0;
      repeat (BIT) begin
         tick();
         n += sampleValid;
      end
      chk(n == 1, "sample point not once per bit");
      off = 50 + $urandom_range(300);
      integ(1'b1, off, cbi_pkg::TQ_CYCLES);
      integ(1'b0, off, BIT);
      integ(1'b1, off, 2 * BIT);
      for (int i = 0; i < 4; i++) begin
         mm = (i == 0) ? 1'b1 : 1'($urandom_range(1));
         frame(mm);
      end
      u_node.pulse(cbi_pkg::GLITCH_LEN - 1);
      waitSig(1, 20, n);
      chk(n < 0, "glitch opened a frame");
      // exception ignored while disabled, re-integrates when enabled
      protocolException = 1'b1;
      tick();
      protocolException = 1'b0;
      tick();
      chk(busIntegrated === 1'b1 && integrating === 1'b0, "exception not ignored");
      pxDis = 1'b0;
      protocolException = 1'b1;
      tick();
      protocolException = 1'b0;
      tick();
      chk(integrating === 1'b1, "exception did not re-integrate");
      waitSig(0, IHI, n);
      chk(n >= ILO - 2, "re-integration timing");
      results();
   end
endmodule : cbi_integration_bench
